// file: sim/dsc_regs_chk.sv
// Assertion checker for the DRAM and shadow configuration bank.
`timescale 1ns/100ps
`default_nettype none
module dsc_regs_chk
    import dsc_pkg::*;
#(
    parameter int MEM_AW = 24
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic mem_cyc_i,
    input wire logic mem_write_i,
    input wire logic [MEM_AW-1:0] mem_addr_i,
    input wire logic [MEM_AW-1:0] mem_addr_o,
    input wire logic mem_to_dram_o,
    input wire logic mem_to_isa_o,
    input wire logic rom_chip_select_n_o,
    input wire logic memory_direction_n_sel_o,
    input wire logic local_memory_n_sel_o,
    input wire logic [2:0] dram_read_leadoff_o,
    input wire logic [2:0] dram_read_burst_o,
    input wire logic isa_bus_clock_o
);
    logic [3:0] seg;
    logic [15:0] off;
    assign seg = mem_addr_i[19:16];
    assign off = mem_addr_i[15:0];
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_rd_ans; s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000; endsequence
    // Cycles are checked only once the previous edge was out of reset.
    sequence s_cyc; $past(nrst_i) && $past(mem_cyc_i); endsequence
    property p_rd_ans; s_rd_take |=> s_rd_ans; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late or wide");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    property p_offset; s_cyc |-> mem_addr_o[15:0] == $past(off); endproperty
    a_offset: assert property (p_offset) else $error("address offset changed");
    property p_remap;
        s_cyc |-> mem_addr_o[19:16] == $past(seg)
            || (mem_addr_o[19:16] == DSC_SEG_UPLOAD_DST && $past(seg) == DSC_SEG_UPLOAD_SRC);
    endproperty
    a_remap: assert property (p_remap) else $error("bad segment remap");
    property p_low_dram;
        s_cyc and ($past(seg) < 4'h3 || ($past(seg) > 4'h3 && $past(seg) < 4'hA))
            |-> mem_to_dram_o && !mem_to_isa_o;
    endproperty
    a_low_dram: assert property (p_low_dram) else $error("low memory not on DRAM");
    property p_timing;
        dram_read_burst_o == dram_read_leadoff_o - 3'h1 && dram_read_leadoff_o inside {3'h3, 3'h4, 3'h5};
    endproperty
    a_timing: assert property (p_timing) else $error("bad read burst timing");
    property p_isa; isa_bus_clock_o |=> !isa_bus_clock_o [*2]; endproperty
    a_isa: assert property (p_isa) else $error("ISA clock pulse too close");
    property p_role; !(memory_direction_n_sel_o && local_memory_n_sel_o); endproperty
    a_role: assert property (p_role) else $error("both pin roles selected");
    property p_rom_rd; s_cyc and !$past(mem_write_i) && $past(seg) == DSC_SEG_ROM |-> !rom_chip_select_n_o;
    endproperty
    a_rom_rd: assert property (p_rom_rd) else $error("ROM select missing on read");
endmodule : dsc_regs_chk
bind dsc_regs dsc_regs_chk #(.MEM_AW(MEM_AW)) u_chk (.*);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the DRAM and shadow configuration bank.
`timescale 1ns/100ps
`default_nettype none
module tb
    import dsc_pkg::*;
;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic reset_strap_pin_i = 1'b0, mem_cyc_i = 1'b0, mem_write_i = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [23:0] mem_addr_i = 24'h00_0000, mem_addr_o, ma;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic mem_to_dram_o, mem_to_isa_o, mem_write_drop_o, rom_chip_select_n_o;
    logic memory_direction_n_sel_o, local_memory_n_sel_o, dram_miss_write_ws_o, isa_bus_clock_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] dram_cfg_hi_o, dram_cfg_lo_o, dram_read_leadoff_o, dram_read_burst_o;
    logic [31:0] rnd = 32'h9b8c_f90f;
    logic [7:0] sh;
    logic [3:0] mo;
    int failures = 0, checks = 0, cyc = 0, p;
    dsc_regs #(.MEM_AW(24)) u_dut (.*);
    always #2.5 sys_clk_i = ~sys_clk_i;
    // The ceiling sits well above the several hundred cycles the sequence needs.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            failures++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cnt
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Expected {dram, isa, drop} for a C-segment cycle; copy mode wins over the enables.
    function automatic logic [2:0] dec(input logic [7:0] s, input logic [1:0] b, input logic w);
        if (s[6]) return {w, ~w, 1'b0};
        if (s[b]) return {~(w & s[5]), 1'b0, w & s[5]};
        return 3'b010;
    endfunction : dec
    // Waits end only by the bench timeout; each answer is held one cycle before it is taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge sys_clk_i);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            @(posedge sys_clk_i);
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        @(negedge sys_clk_i);
        while (!s_axi_bvalid) begin
            @(negedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        s_axi_bready <= 1'b1;
        @(negedge sys_clk_i);
        chk(s_axi_bresp, er);
        @(posedge sys_clk_i);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(negedge sys_clk_i);
        while (!s_axi_arready) begin
            @(negedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        s_axi_arvalid <= 1'b0;
        @(negedge sys_clk_i);
        while (!s_axi_rvalid) begin
            @(negedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        s_axi_rready <= 1'b1;
        @(negedge sys_clk_i);
        d = s_axi_rdata;
        chk(s_axi_rresp, er);
        @(posedge sys_clk_i);
        s_axi_rready <= 1'b0;
    endtask : rdr
    task automatic rst_chk(input logic strap);
        logic [7:0] e;
        reset_strap_pin_i <= strap;
        nrst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rdr(DSC_ADDR_DRAM_ONE + 12'(4 * i), rd, DSC_RESP_OKAY);
            e = (i == 0) ? DSC_RST_DRAM_ONE : (i == 1) ? DSC_RST_DRAM_TWO : DSC_RST_C_SHADOW;
            chk(rd[7:0], e);
        end
        chk({dram_cfg_hi_o, dram_cfg_lo_o}, 6'h00);
        chk({dram_read_leadoff_o, dram_read_burst_o}, {3'd5, 3'd4});
        chk({memory_direction_n_sel_o, local_memory_n_sel_o}, {~strap, 1'b0});
    endtask : rst_chk
    task automatic wrb(input logic [11:0] a, input logic [7:0] d);
        wr(a, d, DSC_RESP_OKAY);
        rdr(a, rd, DSC_RESP_OKAY);
        chk(rd, {24'h00_0000, d});
    endtask : wrb
    task automatic mem(input logic w, input logic [23:0] a);
        mem_cyc_i <= 1'b1;
        mem_write_i <= w;
        mem_addr_i <= a;
        @(posedge sys_clk_i);
        mem_cyc_i <= 1'b0;
        @(negedge sys_clk_i);
        mo = {mem_to_dram_o, mem_to_isa_o, mem_write_drop_o, rom_chip_select_n_o};
        ma = mem_addr_o;
        @(posedge sys_clk_i);
    endtask : mem
    task automatic isa_per(output int q);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        while (!isa_bus_clock_o && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
        q = 0;
        do begin
            @(negedge sys_clk_i);
            q++;
        end while (!isa_bus_clock_o && q < 20);
        @(posedge sys_clk_i);
    endtask : isa_per
    initial begin
        rst_chk(1'b0);
        rdr(12'h09C, rd, DSC_RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        wr(12'h09C, 8'hFF, DSC_RESP_SLVERR);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            wrb(DSC_ADDR_DRAM_ONE, {1'b0, rnd[6:4], 1'b0, rnd[2:0]});
            chk({dram_cfg_hi_o, dram_cfg_lo_o}, {rnd[6:4], rnd[2:0]});
            wrb(DSC_ADDR_DRAM_TWO, {rnd[7], k[1:0], rnd[8], 2'b11, k[1:0]});
            chk(dram_read_leadoff_o, (k == 0) ? 3 : (k == 3) ? 5 : 4);
            chk(dram_read_burst_o, (k == 0) ? 2 : (k == 3) ? 4 : 3);
            if (k != 2) chk(dram_miss_write_ws_o, k == 1);
            chk({memory_direction_n_sel_o, local_memory_n_sel_o}, {~rnd[7], rnd[7]});
            isa_per(p);
            isa_per(p);
            chk_cnt(p, 6 - k);
        end
        wrb(DSC_ADDR_DRAM_ONE, 8'h80);
        mem(1'b0, 24'h03_5A5A);
        chk(ma, 24'h0B_5A5A);
        wrb(DSC_ADDR_DRAM_ONE, 8'h00);
        mem(1'b1, 24'h03_5A5A);
        chk(ma, 24'h03_5A5A);
        mem(1'b0, 24'h0F_0000);
        chk(mo[0], 1'b0);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            // Pass 1 forces protected enables; passes 5 and 7 force copy mode.
            sh = {rnd[7], i[2] & (rnd[6] | i[0]), rnd[5] | (i == 1), 1'b1, rnd[3:0] | {4{i == 1}}};
            wrb(DSC_ADDR_C_SHADOW, sh);
            for (int j = 0; j < 8; j++) begin
                mem(j[0], {8'h0C, j[2:1], rnd[21:8]});
                chk(mo[3:1], dec(sh, j[2:1], j[0]));
                if (sh[6]) mem(j[0], {8'h0E, rnd[23:8]});
                if (sh[6]) chk(mo[3:1], {j[0], ~j[0], 1'b0});
            end
            mem(1'b1, 24'h0F_0000);
            chk(mo[0], !sh[7]);
        end
        rst_chk(1'b1);
        final_report();
    end
endmodule : tb
`default_nettype wire

// file: src/dsc_isa_clk_div.sv
// Divider that makes the ISA bus clock enable pulse from the processor clock.
`timescale 1ns/100ps
`default_nettype none
module dsc_isa_clk_div
    import dsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] div_sel_i,
    output logic isa_bus_clock_o
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // Select 00 divides by six down to 11 dividing by three.
    function automatic logic [2:0] dsc_ratio(input logic [1:0] sel);
        dsc_ratio = DSC_DIV_MAX - {1'b0, sel};
    endfunction : dsc_ratio

    always_comb begin
        if (cnt_r >= dsc_ratio(div_sel_i) - 3'd1) begin
            cnt_nxt = 3'd0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 3'd1;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cnt_r <= 3'd0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign isa_bus_clock_o = tick_r;
endmodule : dsc_isa_clk_div
`default_nettype wire

// file: src/dsc_pkg.sv
// Package holding the register map, reset values and field positions of the config bank.
package dsc_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] DSC_IDX_DRAM_ONE = 8'h24;
    localparam logic [7:0] DSC_IDX_DRAM_TWO = 8'h25;
    localparam logic [7:0] DSC_IDX_C_SHADOW = 8'h26;
    localparam int DSC_AXI_AW = 12;
    localparam logic [11:0] DSC_ADDR_DRAM_ONE = 12'h0090;
    localparam logic [11:0] DSC_ADDR_DRAM_TWO = 12'h0094;
    localparam logic [11:0] DSC_ADDR_C_SHADOW = 12'h0098;
    // Reset values.
    localparam logic [7:0] DSC_RST_DRAM_ONE = 8'h00;
    localparam logic [7:0] DSC_RST_DRAM_TWO = 8'h7C;
    localparam logic [7:0] DSC_RST_C_SHADOW = 8'h10;
    // Field positions.
    localparam int DSC_UPLOAD_BIT = 7;
    localparam int DSC_CFG_HI_LSB = 4;
    localparam int DSC_CFG_LO_LSB = 0;
    localparam int DSC_PIN_ROLE_BIT = 7;
    localparam int DSC_RD_TIME_LSB = 5;
    localparam int DSC_ISA_DIV_LSB = 0;
    localparam int DSC_ROM_WR_BIT = 7;
    localparam int DSC_COPY_BIT = 6;
    localparam int DSC_WPROT_BIT = 5;
    localparam int DSC_SH_EN_LSB = 0;
    // Memory segment codes, address bits 19:16.
    localparam logic [3:0] DSC_SEG_UPLOAD_SRC = 4'h3;
    localparam logic [3:0] DSC_SEG_UPLOAD_DST = 4'hB;
    localparam logic [3:0] DSC_SEG_ISA_LO = 4'hA;
    localparam logic [3:0] DSC_SEG_C = 4'hC;
    localparam logic [3:0] DSC_SEG_E = 4'hE;
    localparam logic [3:0] DSC_SEG_ROM = 4'hF;
    localparam logic [1:0] DSC_RESP_OKAY = 2'b00;
    localparam logic [1:0] DSC_RESP_SLVERR = 2'b10;
    localparam logic [2:0] DSC_DIV_MAX = 3'd6;
endpackage : dsc_pkg

// file: src/dsc_regs.sv
// DRAM and C-segment shadow configuration bank with AXI4-Lite access and memory decode.
`timescale 1ns/100ps
`default_nettype none
module dsc_regs
    import dsc_pkg::*;
#(
    parameter int MEM_AW = 24
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [DSC_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [DSC_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reset_strap_pin_i,
    input wire logic mem_cyc_i,
    input wire logic mem_write_i,
    input wire logic [MEM_AW-1:0] mem_addr_i,
    output logic [MEM_AW-1:0] mem_addr_o,
    output logic mem_to_dram_o,
    output logic mem_to_isa_o,
    output logic mem_write_drop_o,
    output logic rom_chip_select_n_o,
    output logic memory_direction_n_sel_o,
    output logic local_memory_n_sel_o,
    output logic [2:0] dram_cfg_hi_o,
    output logic [2:0] dram_cfg_lo_o,
    output logic [2:0] dram_read_leadoff_o,
    output logic [2:0] dram_read_burst_o,
    output logic dram_miss_write_ws_o,
    output logic isa_bus_clock_o
);
    logic [7:0] dram_one_r, dram_one_nxt;
    logic [7:0] dram_two_r, dram_two_nxt;
    logic [7:0] c_shadow_r, c_shadow_nxt;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [DSC_AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
    logic [7:0] w_byte_r, w_byte_nxt;
    logic w_lane_r, w_lane_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic strap_meta_r, strap_sync_r, strap_low_r, strap_low_nxt;
    logic [MEM_AW-1:0] maddr_r, maddr_nxt;
    logic dram_r, dram_nxt, isa_r, isa_nxt, drop_r, drop_nxt, rom_chip_select_n_n_r, rom_chip_select_n_n_nxt;
    logic memory_direction_n_r, memory_direction_n_nxt, local_memory_n_r, local_memory_n_nxt;
    // Readies sit in their own flops so that no bus output passes through logic.
    logic awready_r, wready_r, arready_r;

    // Maps a byte address to a register select; 2'd3 means unmapped.
    function automatic logic [1:0] dsc_decode(input logic [DSC_AXI_AW-1:0] a);
        if (a == DSC_ADDR_DRAM_ONE) begin
            dsc_decode = 2'd0;
        end else if (a == DSC_ADDR_DRAM_TWO) begin
            dsc_decode = 2'd1;
        end else if (a == DSC_ADDR_C_SHADOW) begin
            dsc_decode = 2'd2;
        end else begin
            dsc_decode = 2'd3;
        end
    endfunction : dsc_decode

    // Write channel: address and data are held apart and joined once both arrived.
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        aw_addr_nxt = aw_addr_r;
        w_byte_nxt = w_byte_r;
        w_lane_nxt = w_lane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        dram_one_nxt = dram_one_r;
        dram_two_nxt = dram_two_r;
        c_shadow_nxt = c_shadow_r;
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            w_byte_nxt = s_axi_wdata[7:0];
            w_lane_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !bvalid_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = DSC_RESP_OKAY;
            // Reserved bits are stored as written, so software sees its own value back.
            if (dsc_decode(aw_addr_r) == 2'd0) begin
                if (w_lane_r) dram_one_nxt = w_byte_r;
            end else if (dsc_decode(aw_addr_r) == 2'd1) begin
                if (w_lane_r) dram_two_nxt = w_byte_r;
            end else if (dsc_decode(aw_addr_r) == 2'd2) begin
                if (w_lane_r) c_shadow_nxt = w_byte_r;
            end else begin
                bresp_nxt = DSC_RESP_SLVERR;
            end
        end
    end

    // Read channel: one read under way; data is valid the cycle after the address.
    always_comb begin
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = DSC_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (dsc_decode(s_axi_araddr) == 2'd0) begin
                rdata_nxt[7:0] = dram_one_r;
            end else if (dsc_decode(s_axi_araddr) == 2'd1) begin
                rdata_nxt[7:0] = dram_two_r;
            end else if (dsc_decode(s_axi_araddr) == 2'd2) begin
                rdata_nxt[7:0] = c_shadow_r;
            end else begin
                rresp_nxt = DSC_RESP_SLVERR;
            end
        end
    end

    // Memory decode, registered so a register write governs the following cycles only.
    always_comb begin
        logic [3:0] seg;
        logic [1:0] blk;
        logic in_copy;
        seg = mem_addr_i[19:16];
        blk = mem_addr_i[15:14];
        in_copy = (seg >= DSC_SEG_C) && (seg <= DSC_SEG_E);
        maddr_nxt = mem_addr_i;
        dram_nxt = 1'b0;
        isa_nxt = 1'b0;
        drop_nxt = 1'b0;
        rom_chip_select_n_n_nxt = 1'b1;
        if (mem_cyc_i) begin
            if (dram_one_r[DSC_UPLOAD_BIT] && seg == DSC_SEG_UPLOAD_SRC) begin
                maddr_nxt[19:16] = DSC_SEG_UPLOAD_DST;
            end
            if (seg < DSC_SEG_ISA_LO) begin
                dram_nxt = 1'b1;
            end else if (c_shadow_r[DSC_COPY_BIT] && in_copy) begin
                dram_nxt = mem_write_i;
                isa_nxt = !mem_write_i;
            end else if (seg == DSC_SEG_C && c_shadow_r[DSC_SH_EN_LSB + 32'(blk)]) begin
                // Protected writes are swallowed here rather than forwarded to ISA.
                dram_nxt = !(mem_write_i && c_shadow_r[DSC_WPROT_BIT]);
                drop_nxt = mem_write_i && c_shadow_r[DSC_WPROT_BIT];
            end else begin
                isa_nxt = 1'b1;
            end
            if (seg == DSC_SEG_ROM) begin
                rom_chip_select_n_n_nxt = mem_write_i && !c_shadow_r[DSC_ROM_WR_BIT];
            end
        end
        // The pin role only follows the bit when the strap came up low.
        memory_direction_n_nxt = strap_low_r && !dram_two_r[DSC_PIN_ROLE_BIT];
        local_memory_n_nxt = strap_low_r && dram_two_r[DSC_PIN_ROLE_BIT];
    end

    // The strap is caught while reset is held, after two synchronising flops.
    always_comb begin
        strap_low_nxt = strap_low_r;
        if (!nrst_i) begin
            strap_low_nxt = !strap_sync_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        strap_meta_r <= reset_strap_pin_i;
        strap_sync_r <= strap_meta_r;
        strap_low_r <= strap_low_nxt;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            dram_one_r <= DSC_RST_DRAM_ONE;
            dram_two_r <= DSC_RST_DRAM_TWO;
            c_shadow_r <= DSC_RST_C_SHADOW;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= DSC_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= DSC_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            maddr_r <= '0;
            dram_r <= 1'b0;
            isa_r <= 1'b0;
            drop_r <= 1'b0;
            rom_chip_select_n_n_r <= 1'b1;
            memory_direction_n_r <= 1'b0;
            local_memory_n_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end else begin
            dram_one_r <= dram_one_nxt;
            dram_two_r <= dram_two_nxt;
            c_shadow_r <= c_shadow_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_byte_r <= w_byte_nxt;
            w_lane_r <= w_lane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            maddr_r <= maddr_nxt;
            dram_r <= dram_nxt;
            isa_r <= isa_nxt;
            drop_r <= drop_nxt;
            rom_chip_select_n_n_r <= rom_chip_select_n_n_nxt;
            memory_direction_n_r <= memory_direction_n_nxt;
            local_memory_n_r <= local_memory_n_nxt;
            awready_r <= !aw_held_nxt;
            wready_r <= !w_held_nxt;
            arready_r <= !rvalid_nxt;
        end
    end

    // Read burst timing: 00 gives 3-2-2-2, 01 and 10 give 4-3-3-3, 11 gives 5-4-4-4.
    logic [2:0] lead_r, burst_r;
    logic miss_ws_r;
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            lead_r <= 3'd5;
            burst_r <= 3'd4;
            miss_ws_r <= 1'b0;
        end else begin
            case (dram_two_r[DSC_RD_TIME_LSB +: 2])
                2'b00: begin
                    lead_r <= 3'd3;
                    burst_r <= 3'd2;
                end
                2'b11: begin
                    lead_r <= 3'd5;
                    burst_r <= 3'd4;
                end
                default: begin
                    lead_r <= 3'd4;
                    burst_r <= 3'd3;
                end
            endcase
            miss_ws_r <= (dram_two_r[DSC_RD_TIME_LSB +: 2] == 2'b01);
        end
    end

    logic [2:0] cfg_hi_r, cfg_lo_r;
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cfg_hi_r <= 3'd0;
            cfg_lo_r <= 3'd0;
        end else begin
            cfg_hi_r <= dram_one_r[DSC_CFG_HI_LSB +: 3];
            cfg_lo_r <= dram_one_r[DSC_CFG_LO_LSB +: 3];
        end
    end

    dsc_isa_clk_div u_div (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .div_sel_i(dram_two_r[DSC_ISA_DIV_LSB +: 2]),
        .isa_bus_clock_o(isa_bus_clock_o)
    );

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign mem_addr_o = maddr_r;
    assign mem_to_dram_o = dram_r;
    assign mem_to_isa_o = isa_r;
    assign mem_write_drop_o = drop_r;
    assign rom_chip_select_n_o = rom_chip_select_n_n_r;
    assign memory_direction_n_sel_o = memory_direction_n_r;
    assign local_memory_n_sel_o = local_memory_n_r;
    assign dram_cfg_hi_o = cfg_hi_r;
    assign dram_cfg_lo_o = cfg_lo_r;
    assign dram_read_leadoff_o = lead_r;
    assign dram_read_burst_o = burst_r;
    assign dram_miss_write_ws_o = miss_ws_r;
endmodule : dsc_regs
`default_nettype wire
